// file: design/exp_controller.sv
`timescale 1ns/10ps
module exp_controller
  import exp_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  exp_link_if.host link
);
  exp_host_state_t st_q, st_d;
  logic [15:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [2:0] bit_q, bit_d;
  logic [4:0] op_q, op_d;
  logic [7:0] tx_q, tx_d, rx_q, rx_d;
  logic ack_q, ack_d, own_q, own_d, ref_q, ref_d, scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic tick, wr_take, line_busy;
  exp_host_state_t after_byte;

  exp_line_watch u_watch (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(link.scl),
    .sda_i(link.sda),
    .scl_rise_o(),
    .scl_fall_o(),
    .start_o(),
    .stop_o(),
    .busy_o(line_busy)
  );

  assign tick = (div_q == 16'(QTR - 1));
  assign wr_take = psel_i & penable_i & pready_q & pwrite_i;

  always_comb begin
    if (op_q[CMD_WRITE]) begin
      after_byte = H_WBIT;
    end else if (op_q[CMD_READ]) begin
      after_byte = H_RBIT;
    end else if (op_q[CMD_STOP]) begin
      after_byte = H_STOP;
    end else begin
      after_byte = H_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    div_d = (st_q == H_IDLE || tick) ? 16'h0000 : div_q + 16'h0001;
    ph_d = ph_q;
    bit_d = bit_q;
    op_d = op_q;
    tx_d = tx_q;
    rx_d = rx_q;
    ack_d = ack_q;
    own_d = own_q;
    ref_d = ref_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    if (st_q == H_IDLE) begin
      ph_d = PH_SET;
      bit_d = 3'h0;
      if (wr_take && paddr_i == APB_CTRL) begin
        ref_d = 1'b0;
        // a new start needs a quiet bus unless this end already holds it
        if (pwdata_i[CMD_START] && line_busy && !own_q) begin
          ref_d = 1'b1;
        end else if (!pwdata_i[CMD_START] && !own_q) begin
          ref_d = 1'b1;
        end else begin
          op_d = pwdata_i[4:0];
          st_d = pwdata_i[CMD_START] ? H_START : H_IDLE;
          if (!pwdata_i[CMD_START]) begin
            op_d = pwdata_i[4:0];
          end
        end
      end else if (op_q[CMD_WRITE] | op_q[CMD_READ] | op_q[CMD_STOP]) begin
        st_d = after_byte;
      end
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      case (st_q)
        H_START: begin
          if (ph_q == PH_SET) sda_oe_d = 1'b0;
          if (ph_q == PH_RISE) scl_oe_d = 1'b0;
          if (ph_q == PH_MID) sda_oe_d = 1'b1;
          if (ph_q == PH_FALL) begin
            scl_oe_d = 1'b1;
            own_d = 1'b1;
            op_d[CMD_START] = 1'b0;
            st_d = after_byte;
          end
        end
        H_WBIT: begin
          if (ph_q == PH_SET) sda_oe_d = ~tx_q[7];
          if (ph_q == PH_RISE) scl_oe_d = 1'b0;
          if (ph_q == PH_FALL) begin
            scl_oe_d = 1'b1;
            tx_d = {tx_q[6:0], 1'b0};
            bit_d = bit_q + 3'h1;
            if (bit_q == BIT_LAST) st_d = H_WACK;
          end
        end
        H_WACK, H_RBIT: begin
          if (ph_q == PH_SET) sda_oe_d = 1'b0;
          if (ph_q == PH_RISE) scl_oe_d = 1'b0;
          if (ph_q == PH_MID && st_q == H_WACK) ack_d = ~link.sda;
          if (ph_q == PH_MID && st_q == H_RBIT) rx_d = {rx_q[6:0], link.sda};
          if (ph_q == PH_FALL) begin
            scl_oe_d = 1'b1;
            bit_d = bit_q + 3'h1;
            if (st_q == H_WACK) begin
              op_d[CMD_WRITE] = 1'b0;
              st_d = op_q[CMD_STOP] ? H_STOP : H_IDLE;
            end else if (bit_q == BIT_LAST) begin
              st_d = H_RACK;
            end
          end
        end
        H_RACK: begin
          if (ph_q == PH_SET) sda_oe_d = ~op_q[CMD_NACK];
          if (ph_q == PH_RISE) scl_oe_d = 1'b0;
          if (ph_q == PH_FALL) begin
            scl_oe_d = 1'b1;
            sda_oe_d = 1'b0;
            op_d[CMD_READ] = 1'b0;
            st_d = op_q[CMD_STOP] ? H_STOP : H_IDLE;
          end
        end
        H_STOP: begin
          if (ph_q == PH_SET) sda_oe_d = 1'b1;
          if (ph_q == PH_RISE) scl_oe_d = 1'b0;
          if (ph_q == PH_MID) sda_oe_d = 1'b0;
          if (ph_q == PH_FALL) begin
            own_d = 1'b0;
            op_d = 5'h00;
            st_d = H_IDLE;
          end
        end
        default: st_d = H_IDLE;
      endcase
    end
    if (wr_take && paddr_i == APB_TXD && st_q == H_IDLE) begin
      tx_d = pwdata_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data is registered in the setup cycle so the answer comes from a flop
  always_comb begin
    pready_d = psel_i & ~penable_i;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (psel_i && !penable_i) begin
      prdata_d = 32'h0000_0000;
      case (paddr_i)
        APB_CTRL: prdata_d[4:0] = op_q;
        APB_TXD: prdata_d[7:0] = tx_q;
        APB_RXD: prdata_d[7:0] = rx_q;
        APB_STAT: begin
          prdata_d[STAT_BUSY] = (st_q != H_IDLE);
          prdata_d[STAT_ACK] = ack_q;
          prdata_d[STAT_OWN] = own_q;
          prdata_d[STAT_REFUSED] = ref_q;
        end
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= H_IDLE;
      div_q <= 16'h0000;
      ph_q <= PH_SET;
      bit_q <= 3'h0;
      op_q <= 5'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      ack_q <= 1'b0;
      own_q <= 1'b0;
      ref_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      op_q <= op_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      ack_q <= ack_d;
      own_q <= own_d;
      ref_q <= ref_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // no clock stretching: the target here never holds the clock low
  assign link.scl_o = 1'b0;
  assign link.scl_oe = scl_oe_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
endmodule // exp_controller

// file: design/exp_line_watch.sv
`timescale 1ns/10ps
module exp_line_watch (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o,
  output logic busy_o
);
  logic scl_q, scl_d, sda_q, sda_d, busy_q, busy_d;

  always_comb begin
    scl_d = scl_i;
    sda_d = sda_i;
    busy_d = busy_q;
    if (start_o) begin
      busy_d = 1'b1;
    end else if (stop_o) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      busy_q <= busy_d;
    end
  end

  assign scl_rise_o = scl_i & ~scl_q;
  assign scl_fall_o = ~scl_i & scl_q;
  // data edges while the clock stays high mark start and stop
  assign start_o = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_o = scl_i & scl_q & ~sda_q & sda_i;
  assign busy_o = busy_q;
endmodule // exp_line_watch

// file: design/exp_target.sv
`timescale 1ns/10ps
module exp_target
  import exp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] target_select_i,
  input wire logic [15:0] port_in_i,
  output logic [15:0] out_level_o,
  output logic [15:0] dir_in_o,
  output logic [15:0] pol_inv_o,
  exp_link_if.dev link
);
  exp_dev_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d, ptr_q, ptr_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic full_q, full_d, rw_q, rw_d, ackseen_q, ackseen_d, oe_q, oe_d;
  logic [7:0] output_level_low_port_q, output_level_low_port_d;
  logic [7:0] output_level_high_port_q, output_level_high_port_d;
  logic [7:0] pol_q [2];
  logic [7:0] pol_d [2];
  logic [7:0] cfg_q [2];
  logic [7:0] cfg_d [2];
  logic wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  exp_line_watch u_watch (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(link.scl),
    .sda_i(link.sda),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(bus_start),
    .stop_o(bus_stop),
    .busy_o()
  );

  function automatic logic [7:0] rd_value(input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      REG_IN_LO: v = port_in_i[7:0] ^ pol_q[0];
      REG_IN_HI: v = port_in_i[15:8] ^ pol_q[1];
      REG_OUT_LO: v = output_level_low_port_q;
      REG_OUT_HI: v = output_level_high_port_q;
      REG_POL_LO: v = pol_q[0];
      REG_POL_HI: v = pol_q[1];
      REG_CFG_LO: v = cfg_q[0];
      REG_CFG_HI: v = cfg_q[1];
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    sh_d = sh_q;
    tx_d = tx_q;
    full_d = full_q;
    rw_d = rw_q;
    ackseen_d = ackseen_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    wr_idx = ptr_q;
    wr_data = sh_q;
    // pointer is left alone here so a bare restart read continues
    if (bus_start) begin
      st_d = D_ADDR;
      cnt_d = 3'h0;
      full_d = 1'b0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      st_d = D_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        D_ADDR, D_CMD, D_WDAT: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], link.sda};
            cnt_d = cnt_q + 3'h1;
            full_d = (cnt_q == BIT_LAST);
          end else if (scl_fall && full_q) begin
            full_d = 1'b0;
            oe_d = 1'b1;
            if (st_q == D_ADDR) begin
              if (sh_q[7:1] == {TGT_ADDR_HI, target_select_i}) begin
                rw_d = sh_q[0];
                st_d = D_AACK;
              end else begin
                oe_d = 1'b0;
                st_d = D_IDLE;
              end
            end else if (st_q == D_CMD) begin
              ptr_d = sh_q[2:0];
              st_d = D_CACK;
            end else begin
              // input ports are read only, yet the pointer still moves
              wr_en = (ptr_q[2:1] != REG_IN_LO[2:1]);
              ptr_d = {ptr_q[2:1], ~ptr_q[0]};
              st_d = D_WACK;
            end
          end
        end
        D_AACK, D_CACK, D_WACK: begin
          if (scl_rise && st_q == D_AACK && rw_q) begin
            tx_d = rd_value(ptr_q);
          end else if (scl_fall) begin
            cnt_d = 3'h0;
            oe_d = 1'b0;
            if (st_q == D_AACK && rw_q) begin
              oe_d = ~tx_q[7];
              st_d = D_TX;
            end else if (st_q == D_AACK) begin
              st_d = D_CMD;
            end else begin
              st_d = D_WDAT;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              oe_d = 1'b0;
              st_d = D_MACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = ~tx_q[6];
            end
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            ptr_d = {ptr_q[2:1], ~ptr_q[0]};
            ackseen_d = ~link.sda;
            tx_d = rd_value({ptr_q[2:1], ~ptr_q[0]});
          end else if (scl_fall) begin
            cnt_d = 3'h0;
            if (ackseen_q) begin
              oe_d = ~tx_q[7];
              st_d = D_TX;
            end else begin
              // a nack ends the read; line stays released
              st_d = D_IDLE;
            end
          end
        end
        D_IDLE: begin
          oe_d = 1'b0;
        end
        default: begin
          st_d = D_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    output_level_low_port_d = output_level_low_port_q;
    output_level_high_port_d = output_level_high_port_q;
    pol_d = pol_q;
    cfg_d = cfg_q;
    if (wr_en) begin
      case (wr_idx)
        REG_OUT_LO: output_level_low_port_d = wr_data;
        REG_OUT_HI: output_level_high_port_d = wr_data;
        REG_POL_LO: pol_d[0] = wr_data;
        REG_POL_HI: pol_d[1] = wr_data;
        REG_CFG_LO: cfg_d[0] = wr_data;
        REG_CFG_HI: cfg_d[1] = wr_data;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sys_rst_i stands for the supply-level reset; nothing else resets
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= D_IDLE;
      cnt_q <= 3'h0;
      ptr_q <= REG_IN_LO;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      full_q <= 1'b0;
      rw_q <= 1'b0;
      ackseen_q <= 1'b0;
      oe_q <= 1'b0;
      output_level_low_port_q <= OUT_RST;
      output_level_high_port_q <= OUT_RST;
      pol_q[0] <= POL_RST;
      pol_q[1] <= POL_RST;
      cfg_q[0] <= CFG_RST;
      cfg_q[1] <= CFG_RST;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      full_q <= full_d;
      rw_q <= rw_d;
      ackseen_q <= ackseen_d;
      oe_q <= oe_d;
      output_level_low_port_q <= output_level_low_port_d;
      output_level_high_port_q <= output_level_high_port_d;
      pol_q <= pol_d;
      cfg_q <= cfg_d;
    end
  end

  // open drain: the driven level is always low, the enable does the work
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_q;
  assign out_level_o = {output_level_high_port_q, output_level_low_port_q};
  assign dir_in_o = {cfg_q[1], cfg_q[0]};
  assign pol_inv_o = {pol_q[1], pol_q[0]};
endmodule // exp_target

// file: pkg/exp_link_if.sv
`timescale 1ns/10ps
interface exp_link_if;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // open drain with pull-up: low while any enabled driver pulls low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output scl_o, output scl_oe, output host_sda_o, output host_sda_oe,
    input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// file: pkg/exp_pkg.sv
package exp_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int SCL_HZ = 400_000;
  // rounded up so the bus never runs above its rate
  localparam int QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam logic [3:0] TGT_ADDR_HI = 4'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_MID = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [2:0] REG_IN_LO = 3'h0;
  localparam logic [2:0] REG_IN_HI = 3'h1;
  localparam logic [2:0] REG_OUT_LO = 3'h2;
  localparam logic [2:0] REG_OUT_HI = 3'h3;
  localparam logic [2:0] REG_POL_LO = 3'h4;
  localparam logic [2:0] REG_POL_HI = 3'h5;
  localparam logic [2:0] REG_CFG_LO = 3'h6;
  localparam logic [2:0] REG_CFG_HI = 3'h7;
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hff;
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_TXD = 8'h04;
  localparam logic [7:0] APB_RXD = 8'h08;
  localparam logic [7:0] APB_STAT = 8'h0c;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_WRITE = 2;
  localparam int CMD_READ = 3;
  localparam int CMD_NACK = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_OWN = 2;
  localparam int STAT_REFUSED = 3;
  typedef enum logic [8:0] {
    D_IDLE = 9'h001, D_ADDR = 9'h002, D_AACK = 9'h004, D_CMD = 9'h008, D_CACK = 9'h010,
    D_WDAT = 9'h020, D_WACK = 9'h040, D_TX = 9'h080, D_MACK = 9'h100
  } exp_dev_state_t;
  typedef enum logic [6:0] {
    H_IDLE = 7'h01, H_START = 7'h02, H_WBIT = 7'h04, H_WACK = 7'h08,
    H_RBIT = 7'h10, H_RACK = 7'h20, H_STOP = 7'h40
  } exp_host_state_t;
endpackage

// file: test/exp_chk.sv
`timescale 1ns/10ps
module exp_chk
  import exp_pkg::*;
#(
  parameter logic [2:0] SEL = 3'h0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, busy_q, busy_d, rw_q, rw_d, match_q, match_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] byte_q, byte_d;
  logic [7:0] sh_q, sh_d;
  logic start_w, stop_w, rise_w, ack_w, adr_ok_w;
  //////////////////////////////////////////////////////////////////////////////
  // frame tracker, byte count saturates since only first/later matters
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  assign rise_w = scl && !scl_q;
  assign ack_w = rise_w && (cnt_q == 4'h8);
  assign adr_ok_w = (sh_q[7:1] == {TGT_ADDR_HI, SEL});
  always_comb begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    byte_d = byte_q;
    sh_d = sh_q;
    rw_d = rw_q;
    match_d = match_q;
    if (start_w) begin
      busy_d = 1'b1;
      cnt_d = 4'h0;
      byte_d = 2'h0;
    end else if (stop_w) begin
      busy_d = 1'b0;
    end else if (rise_w) begin
      sh_d = {sh_q[6:0], sda};
      cnt_d = ack_w ? 4'h0 : cnt_q + 4'h1;
      if (ack_w && byte_q != 2'h2) begin
        byte_d = byte_q + 2'h1;
      end
      if (ack_w && byte_q == 2'h0) begin
        rw_d = sh_q[0];
        match_d = adr_ok_w;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {scl_q, sda_q, busy_q, rw_q, match_q} <= 5'h18;
      cnt_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
    end else begin
      {scl_q, sda_q, busy_q, rw_q, match_q} <= {scl, sda, busy_d, rw_d, match_d};
      cnt_q <= cnt_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rst_idle; $fell(sys_rst_i) |-> !dev_sda_oe && !scl_oe && !host_sda_oe; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("lines not released after reset");
  property p_dev_edge; $changed(dev_sda_oe) |-> !scl; endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("target moved sda with scl high");
  property p_bit_stands; scl && scl_q |-> $stable(dev_sda_oe); endproperty
  a_bit_stands: assert property (p_bit_stands) else $error("target bit not stable");
  property p_quiet; (!busy_q || (byte_q != 2'h0 && !match_q)) |-> !dev_sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("target drives while not addressed");
  property p_addr_ack; ack_w && byte_q == 2'h0 |-> dev_sda_oe == adr_ok_w; endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_wr_ack; ack_w && byte_q != 2'h0 && !rw_q && match_q |-> dev_sda_oe; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");
  property p_rd_rel; ack_w && byte_q != 2'h0 && rw_q |-> !dev_sda_oe; endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("target holds sda in read ack");
  property p_ack_holds; ack_w && dev_sda_oe |=> dev_sda_oe [*3]; endproperty
  a_ack_holds: assert property (p_ack_holds) else $error("ack dropped early");
  c_wr: cover property (ack_w && byte_q != 2'h0 && !rw_q && dev_sda_oe);
  c_rd: cover property (ack_w && byte_q != 2'h0 && rw_q);
  c_miss: cover property (ack_w && byte_q == 2'h0 && !adr_ok_w);
endmodule // exp_chk

// file: test/expander_register_pair_access_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module expander_register_pair_access_test;
  import exp_pkg::*;
  typedef struct packed {
    logic [7:0] cmd, d0, d1;
    logic [15:0] out, pol, dir;
  } exp_row_t;
  logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r;
  logic [2:0] target_select_i;
  logic [15:0] port_in_i, out_level_o, dir_in_o, pol_inv_o;
  int bad_count, n_compared;
  exp_row_t rows [5];
  exp_link_if link();
  exp_controller #(.QTR(4)) i_exp_controller (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .link(link));
  exp_target i_exp_target (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .target_select_i(target_select_i), .port_in_i(port_in_i), .out_level_o(out_level_o),
    .dir_in_o(dir_in_o), .pol_inv_o(pol_inv_o), .link(link));
  exp_chk #(.SEL(3'h5)) i_exp_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_o(link.scl_o),
    .scl_oe(link.scl_oe), .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
  //////////////////////////////////////////////////////////////////////////////
  // one apb transfer; waits an edge after release so psel is never set twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // leaves the final status word in r
  task automatic xfer(input logic [4:0] bits, input logic [7:0] d);
    apb(1'b1, APB_TXD, {24'h0, d});
    apb(1'b1, APB_CTRL, {27'h0, bits});
    r = 32'h1;
    while (r[STAT_BUSY] !== 1'b0) apb(1'b0, APB_STAT, 32'h0);
  endtask
  task automatic rd(input logic [4:0] bits, input logic [7:0] ex);
    xfer(bits, 8'h00);
    apb(1'b0, APB_RXD, 32'h0);
    `CHK(r[7:0], ex)
  endtask
  task automatic regs(input logic [15:0] o, input logic [15:0] p, input logic [15:0] d);
    `CHK(out_level_o, o)
    `CHK(pol_inv_o, p)
    `CHK(dir_in_o, d)
  endtask
  task automatic summarize;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
  initial begin
    {sys_rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    target_select_i = 3'h5;
    port_in_i = 16'hbe5a;
    bad_count = 0;
    n_compared = 0;
    rows = '{'{8'h03, 8'ha5, 8'h3c, 16'ha53c, 16'h0000, 16'hffff},
             '{8'h04, 8'h12, 8'h34, 16'ha53c, 16'h3412, 16'hffff},
             '{8'h07, 8'h0f, 8'hf0, 16'ha53c, 16'h3412, 16'h0ff0},
             '{8'h02, 8'h81, 8'h7e, 16'h7e81, 16'h3412, 16'h0ff0},
             '{8'h05, 8'h00, 8'h00, 16'h7e81, 16'h0000, 16'h0ff0}};
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    regs(16'hffff, 16'h0000, 16'hffff);
    $display("test reset done");
    foreach (rows[i]) begin
      xfer(5'h05, 8'h4a);
      `CHK(r[STAT_ACK], 1'b1)
      xfer(5'h04, rows[i].cmd);
      xfer(5'h04, rows[i].d0);
      xfer(5'h06, rows[i].d1);
      regs(rows[i].out, rows[i].pol, rows[i].dir);
      xfer(5'h05, 8'h4a);
      xfer(5'h04, rows[i].cmd);
      xfer(5'h05, 8'h4b);
      rd(5'h08, rows[i].d0);
      rd(5'h1a, rows[i].d1);
    end
    $display("test pair rows done");
    // three bytes: third lands on the first register again
    xfer(5'h05, 8'h4a);
    xfer(5'h04, 8'h06);
    xfer(5'h04, 8'h11);
    xfer(5'h04, 8'h22);
    xfer(5'h06, 8'h33);
    regs(16'h7e81, 16'h0000, 16'h2233);
    $display("test pair wrap done");
    xfer(5'h05, 8'h4a);
    xfer(5'h04, 8'h01);
    xfer(5'h04, 8'h99);
    `CHK(r[STAT_ACK], 1'b1)
    xfer(5'h05, 8'h4b);
    // byte already captured at the address ack, so this pin change must not show
    port_in_i <= 16'h3cc3;
    rd(5'h08, 8'h5a);
    rd(5'h1a, 8'h3c);
    regs(16'h7e81, 16'h0000, 16'h2233);
    xfer(5'h05, 8'h4b);
    rd(5'h1a, 8'hc3);
    $display("test input pair done");
    xfer(5'h05, 8'h4c);
    `CHK(r[STAT_ACK], 1'b0)
    xfer(5'h02, 8'h00);
    // a byte command without holding the bus must be refused
    apb(1'b1, APB_CTRL, 32'h4);
    apb(1'b0, APB_STAT, 32'h0);
    `CHK(r[STAT_REFUSED], 1'b1)
    `CHK(r[STAT_OWN], 1'b0)
    apb(1'b1, 8'h10, 32'h5a);
    `CHK(e, 1'b1)
    $display("test refusals done");
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    regs(16'hffff, 16'h0000, 16'hffff);
    $display("test second reset done");
    summarize();
  end
endmodule // expander_register_pair_access_test
